/* File: rtl/sosx_pkg.sv */
// package: constants of the sensor output sync and exposure block
package sosx_pkg;

  // ---------------------------------------------------------------
  // word format
  // ---------------------------------------------------------------
  localparam int          WMAX      = 12;
  localparam logic [1:0]  BM_12     = 2'h0;
  localparam logic [1:0]  BM_10     = 2'h1;
  localparam logic [1:0]  BM_8      = 2'h2;
  localparam logic [11:0] IDLE_CTL  = 12'h080;
  localparam int          B_PIX     = 0;
  localparam int          B_ROW     = 1;
  localparam int          B_FRM     = 2;
  localparam int          B_FOT     = 3;
  localparam int          B_INTA    = 4;
  localparam int          B_INTB    = 5;
  localparam int          B_CONST   = 7;

  // ---------------------------------------------------------------
  // device register map and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]  A_EXP_SRC = 7'h46;
  localparam logic [6:0]  A_EXP_LO  = 7'h47;
  localparam logic [6:0]  A_EXP_HI  = 7'h48;
  localparam logic [6:0]  A_OUT_SEL = 7'h51;
  localparam logic [6:0]  A_OVH     = 7'h52;
  localparam logic [6:0]  A_LINE    = 7'h55;
  localparam logic [6:0]  A_TP1     = 7'h59;
  localparam logic [6:0]  A_BMODE   = 7'h76;
  localparam logic [15:0] R_EXP_LO  = 16'h0600;
  localparam logic [15:0] R_OVH     = 16'h0C01;
  localparam logic [15:0] R_LINE    = 16'h0080;
  localparam logic [11:0] R_TP1     = 12'h055;
  localparam logic [2:0]  MAX_SEL   = 3'h5;

  // ---------------------------------------------------------------
  // timing in word periods
  // ---------------------------------------------------------------
  localparam logic [5:0]  FOT_MULT  = 6'h22;
  localparam logic [47:0] BURST_LEN = 48'h80;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  H_CMD     = 4'h0;
  localparam logic [3:0]  H_DADDR   = 4'h1;
  localparam logic [3:0]  H_DDATA   = 4'h2;
  localparam logic [3:0]  H_STAT    = 4'h3;
  localparam logic [3:0]  H_PCNT    = 4'h4;
  localparam logic [3:0]  H_PIX     = 4'h5;
  localparam logic [3:0]  H_MODE    = 4'h6;

  // bits per word for a bit-mode code; unknown codes fall back to 12
  function automatic logic [3:0] sosx_wbits(input logic [1:0] m);
    case (m)
      BM_10:   return 4'hA;
      BM_8:    return 4'h8;
      default: return 4'hC;
    endcase
  endfunction

endpackage

/* File: rtl/sosx_link.sv */
// interface: serial channels, exposure pins and register port
`timescale 1ns/1ps
`default_nettype none
interface sosx_link #(parameter int NCH = 64);
  logic            ctl_bit;
  logic [NCH-1:0]  dat_bit;
  logic            frame_req;
  logic            exp_start;
  logic            reg_we;
  logic [6:0]      reg_addr;
  logic [15:0]     reg_wdata;

  modport dev  (output ctl_bit, dat_bit,
                input  frame_req, exp_start, reg_we, reg_addr, reg_wdata);
  modport host (input  ctl_bit, dat_bit,
                output frame_req, exp_start, reg_we, reg_addr, reg_wdata);
endinterface
`default_nettype wire

/* File: rtl/sosx_ser.sv */
// module: one serial lane, loads a word and shifts it out lsb first
`timescale 1ns/1ps
`default_nettype none
module sosx_ser
  import sosx_pkg::*;
#(
  parameter int W = WMAX
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          load,
  input  wire logic [W-1:0]  word,
  output logic               ser_bit
);

  typedef struct packed {
    logic [W-1:0] sh;
    logic         b;
  } sosx_ser_s;

  sosx_ser_s s_r;
  sosx_ser_s s_nxt;

  // the caller decides the word length by how often it pulses load
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.b  = word[0];
      s_nxt.sh = word >> 1;
    end else begin
      s_nxt.b  = s_r.sh[0];
      s_nxt.sh = s_r.sh >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ser_bit = s_r.b;

endmodule
`default_nettype wire

/* File: rtl/sosx_dev.sv */
// module: sensor end, status word, training words and exposure timing
`timescale 1ns/1ps
`default_nettype none
module sosx_dev
  import sosx_pkg::*;
#(
  parameter int NCH      = 64,
  parameter int ROWS     = 3072,
  parameter int OH_WORDS = 4
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  sosx_link.dev            lk,
  input  wire logic [11:0] pixel_word,
  output logic             pixel_take,
  output logic [11:0]      status_monitor_pins
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NCH < 1 || ROWS < 2 || ROWS % 2 != 0 || ROWS > 8192 ||
      OH_WORDS < 1 || OH_WORDS > 4096) begin : g_bad
    $error("sosx_dev: unsupported parameter values");
  end

  localparam logic [11:0] PASSES = 12'(ROWS / 2 - 1);
  localparam logic [47:0] OH_LST = 48'(OH_WORDS - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_EXPO, S_FOT, S_GAP, S_BURST, S_SLOT
  } sosx_st_e;

  typedef struct packed {
    logic [7:0]  src;
    logic [15:0] exp_lo;
    logic [7:0]  exp_hi;
    logic [2:0]  out_sel;
    logic [15:0] ovh;
    logic [15:0] line;
    logic [11:0] tp1;
    logic [1:0]  bmode;
    logic [2:0]  fr_s;
    logic [2:0]  ex_s;
    logic        fr_pend;
    logic        ex_pend;
    logic [3:0]  bitc;
    sosx_st_e    st;
    logic [47:0] cnt;
    logic [5:0]  bidx;
    logic [11:0] row;
    logic        take;
    logic [11:0] mon;
  } sosx_dev_s;

  sosx_dev_s d_r;
  sosx_dev_s d_nxt;

  logic [11:0] ctl_word;
  logic [11:0] dat_word;
  logic        load;
  logic [3:0]  wb;
  logic [11:0] wmask;
  logic [11:0] tp2;
  logic [47:0] main_lst;
  logic [47:0] fot_lst;
  logic [5:0]  nb_lst;
  logic [23:0] ev;
  logic [23:0] ev1;
  logic [13:0] fot_len;

  // ---------------------------------------------------------------
  // derived values
  // ---------------------------------------------------------------
  assign wb      = sosx_wbits(d_r.bmode);
  assign wmask   = 12'((13'h1 << wb) - 13'h1);
  assign load    = (d_r.bitc == 4'h0);
  assign tp2     = {4'h0, ~d_r.tp1[7:0]};
  assign ev      = {d_r.exp_hi, d_r.exp_lo};
  assign ev1     = (ev == 24'h0) ? 24'h0 : ev - 24'h1;
  // internal length minus the overhead part, as a count-down value
  assign main_lst = 48'(ev1 * ({1'b0, d_r.line} + 17'h1));
  assign fot_len = 14'(d_r.ovh[7:0] * FOT_MULT);
  // an empty overhead part still needs one frame overhead word
  assign fot_lst = (fot_len == 14'h0) ? 48'h0 : 48'(fot_len - 14'h1);
  assign nb_lst  = 6'((7'h1 << d_r.out_sel) - 7'h1);

  // status word from the current word-period state
  always_comb begin
    ctl_word          = '0;
    ctl_word[B_CONST] = 1'b1;
    ctl_word[B_PIX]   = (d_r.st == S_BURST);
    ctl_word[B_ROW]   = (d_r.st == S_BURST) || (d_r.st == S_SLOT);
    ctl_word[B_FRM]   = (d_r.st == S_GAP) || ctl_word[B_ROW];
    ctl_word[B_FOT]   = (d_r.st == S_FOT);
    ctl_word[B_INTA]  = (d_r.st == S_EXPO) || (d_r.st == S_FOT);
    ctl_word[B_INTB]  = ctl_word[B_INTA];
  end

  // data word: pixels only in bursts, align word on the last gap word
  always_comb begin
    if (d_r.st == S_BURST) begin
      dat_word = pixel_word & wmask;
    end else if (d_r.st == S_GAP && d_r.cnt == 48'h0) begin
      dat_word = tp2 & wmask;
    end else begin
      dat_word = d_r.tp1 & wmask;
    end
  end

  // ---------------------------------------------------------------
  // registers, pin edges and sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d_nxt      = d_r;
    d_nxt.take = 1'b0;
    // register port; out_sel is clamped so burst count stays legal
    if (lk.reg_we) begin
      unique case (lk.reg_addr)
        A_EXP_SRC: d_nxt.src    = lk.reg_wdata[7:0];
        A_EXP_LO:  d_nxt.exp_lo = lk.reg_wdata;
        A_EXP_HI:  d_nxt.exp_hi = lk.reg_wdata[7:0];
        A_OUT_SEL: d_nxt.out_sel = (lk.reg_wdata[2:0] > MAX_SEL) ?
                                   MAX_SEL : lk.reg_wdata[2:0];
        A_OVH:     d_nxt.ovh    = lk.reg_wdata;
        A_LINE:    d_nxt.line   = lk.reg_wdata;
        A_TP1:     d_nxt.tp1    = lk.reg_wdata[11:0];
        A_BMODE:   d_nxt.bmode  = lk.reg_wdata[1:0];
        default:   d_nxt.src    = d_r.src;
      endcase
    end
    // pins pass two flops; the third keeps history for edge detect
    d_nxt.fr_s    = {d_r.fr_s[1:0], lk.frame_req};
    d_nxt.ex_s    = {d_r.ex_s[1:0], lk.exp_start};
    d_nxt.fr_pend = d_r.fr_pend | (d_r.fr_s[1] & ~d_r.fr_s[2]);
    d_nxt.ex_pend = d_r.ex_pend | (d_r.ex_s[1] & ~d_r.ex_s[2]);
    // a mode change mid-word must not strand the counter
    d_nxt.bitc = (d_r.bitc >= wb - 4'h1) ? 4'h0 : d_r.bitc + 4'h1;
    if (load) begin
      d_nxt.mon = ctl_word;
    end
    // state moves on the last bit so the next load sees it
    if (d_r.bitc >= wb - 4'h1) begin
      unique case (d_r.st)
        S_IDLE: begin
          // edges seen while idle in the wrong mode are dropped
          if (d_r.src == 8'h0 && d_r.fr_pend) begin
            d_nxt.st  = S_EXPO;
            d_nxt.cnt = main_lst;
          end else if (d_r.src != 8'h0 && d_r.ex_pend) begin
            d_nxt.st  = S_EXPO;
            d_nxt.cnt = '0;
          end
          // an edge found in this very cycle outlives the clear
          d_nxt.fr_pend = d_r.fr_s[1] & ~d_r.fr_s[2];
          d_nxt.ex_pend = d_r.ex_s[1] & ~d_r.ex_s[2];
        end
        S_EXPO: begin
          if (d_r.src != 8'h0) begin
            // word-period steps quantize the external interval
            if (d_r.fr_pend) begin
              d_nxt.st      = S_FOT;
              d_nxt.cnt     = fot_lst;
              d_nxt.fr_pend = d_r.fr_s[1] & ~d_r.fr_s[2];
            end
          end else if (d_r.cnt == 48'h0) begin
            d_nxt.st  = S_FOT;
            d_nxt.cnt = fot_lst;
          end else begin
            d_nxt.cnt = d_r.cnt - 48'h1;
          end
        end
        S_FOT: begin
          if (d_r.cnt == 48'h0) begin
            d_nxt.st  = S_GAP;
            d_nxt.cnt = OH_LST;
            d_nxt.row = '0;
          end else begin
            d_nxt.cnt = d_r.cnt - 48'h1;
          end
        end
        S_GAP: begin
          if (d_r.cnt == 48'h0) begin
            d_nxt.st   = S_BURST;
            d_nxt.cnt  = BURST_LEN - 48'h1;
            d_nxt.bidx = '0;
            d_nxt.take = 1'b1;
          end else begin
            d_nxt.cnt = d_r.cnt - 48'h1;
          end
        end
        S_BURST: begin
          if (d_r.cnt != 48'h0) begin
            d_nxt.cnt  = d_r.cnt - 48'h1;
            d_nxt.take = 1'b1;
          end else if (d_r.bidx != nb_lst) begin
            d_nxt.st = S_SLOT;
          end else if (d_r.row == PASSES) begin
            d_nxt.st = S_IDLE;
          end else begin
            d_nxt.st  = S_GAP;
            d_nxt.cnt = OH_LST;
            d_nxt.row = d_r.row + 12'h1;
          end
        end
        S_SLOT: begin
          d_nxt.st   = S_BURST;
          d_nxt.cnt  = BURST_LEN - 48'h1;
          d_nxt.bidx = d_r.bidx + 6'h1;
          d_nxt.take = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      d_r        <= '0;
      d_r.st     <= S_IDLE;
      d_r.exp_lo <= R_EXP_LO;
      d_r.ovh    <= R_OVH;
      d_r.line   <= R_LINE;
      d_r.tp1    <= R_TP1;
      d_r.mon    <= IDLE_CTL;
    end else begin
      d_r <= d_nxt;
    end
  end

  // ---------------------------------------------------------------
  // serial lanes share one word boundary
  // ---------------------------------------------------------------
  sosx_ser #(.W(WMAX)) u_ctl (
    .clk     (clk),
    .nrst    (nrst),
    .load    (load),
    .word    (ctl_word),
    .ser_bit (lk.ctl_bit)
  );

  for (genvar i = 0; i < NCH; i++) begin : g_lane
    sosx_ser #(.W(WMAX)) u_dat (
      .clk     (clk),
      .nrst    (nrst),
      .load    (load),
      .word    (dat_word),
      .ser_bit (lk.dat_bit[i])
    );
  end

  assign pixel_take          = d_r.take;
  assign status_monitor_pins = d_r.mon;

endmodule
`default_nettype wire

/* File: rtl/sosx_host.sv */
// module: receiver end, deserializes, aligns and drives the sensor
`timescale 1ns/1ps
`default_nettype none
module sosx_host
  import sosx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  sosx_link.host           lk,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata
);

  typedef struct packed {
    logic        fr;
    logic        ex;
    logic        we;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  bmode;
    logic [1:0]  c_s;
    logic [1:0]  d_s;
    logic [11:0] csh;
    logic [11:0] dsh;
    logic [3:0]  bitc;
    logic        aligned;
    logic [11:0] ctlw;
    logic [11:0] tpw;
    logic [11:0] pix;
    logic [23:0] pcnt;
    logic [31:0] rdata;
  } sosx_host_s;

  sosx_host_s h_r;
  sosx_host_s h_nxt;

  logic [3:0]  wb;
  logic [11:0] cwin;
  logic [11:0] dwin;
  logic [11:0] csh_n;
  logic [11:0] dsh_n;

  // ---------------------------------------------------------------
  // lsb-first words sit in the top wb bits of the shift registers
  // ---------------------------------------------------------------
  assign wb    = sosx_wbits(h_r.bmode);
  assign csh_n = {h_r.c_s[1], h_r.csh[11:1]};
  assign dsh_n = {h_r.d_s[1], h_r.dsh[11:1]};
  assign cwin  = csh_n >> (4'hC - wb);
  assign dwin  = dsh_n >> (4'hC - wb);

  always_comb begin
    h_nxt     = h_r;
    h_nxt.we  = 1'b0;
    h_nxt.c_s = {h_r.c_s[0], lk.ctl_bit};
    h_nxt.d_s = {h_r.d_s[0], lk.dat_bit[0]};
    h_nxt.csh = csh_n;
    h_nxt.dsh = dsh_n;
    // hunt for the idle status word, then count whole words
    if (!h_r.aligned) begin
      if (cwin == IDLE_CTL) begin
        h_nxt.aligned = 1'b1;
        h_nxt.bitc    = 4'h0;
        h_nxt.ctlw    = cwin;
      end
    end else if (h_r.bitc >= wb - 4'h1) begin
      h_nxt.bitc = 4'h0;
      h_nxt.ctlw = cwin;
      // only the three valid flags gate sampling
      if (cwin[B_PIX] && cwin[B_ROW] && cwin[B_FRM]) begin
        h_nxt.pix  = dwin;
        h_nxt.pcnt = h_r.pcnt + 24'h1;
      end else begin
        h_nxt.tpw = dwin;
      end
    end else begin
      h_nxt.bitc = h_r.bitc + 4'h1;
    end
    // software port; a realign only works while the sensor idles
    if (sw_wr) begin
      unique case (sw_addr)
        H_CMD: begin
          h_nxt.fr = sw_wdata[0];
          h_nxt.ex = sw_wdata[1];
          if (sw_wdata[2]) begin
            h_nxt.aligned = 1'b0;
          end
          if (sw_wdata[3]) begin
            h_nxt.pcnt = '0;
          end
        end
        H_DADDR: h_nxt.addr = sw_wdata[6:0];
        H_DDATA: begin
          h_nxt.wdata = sw_wdata[15:0];
          h_nxt.we    = 1'b1;
        end
        H_MODE:  h_nxt.bmode = sw_wdata[1:0];
        default: h_nxt.we    = 1'b0;
      endcase
    end
    h_nxt.rdata = '0;
    if (sw_rd) begin
      unique case (sw_addr)
        H_CMD:   h_nxt.rdata = {30'h0, h_r.ex, h_r.fr};
        H_DADDR: h_nxt.rdata = {25'h0, h_r.addr};
        H_DDATA: h_nxt.rdata = {16'h0, h_r.wdata};
        H_STAT:  h_nxt.rdata = {7'h0, h_r.aligned, h_r.tpw, h_r.ctlw};
        H_PCNT:  h_nxt.rdata = {8'h0, h_r.pcnt};
        H_PIX:   h_nxt.rdata = {20'h0, h_r.pix};
        H_MODE:  h_nxt.rdata = {30'h0, h_r.bmode};
        default: h_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign lk.frame_req = h_r.fr;
  assign lk.exp_start = h_r.ex;
  assign lk.reg_we    = h_r.we;
  assign lk.reg_addr  = h_r.addr;
  assign lk.reg_wdata = h_r.wdata;
  assign sw_rdata     = h_r.rdata;

endmodule
`default_nettype wire

/* File: dv/sosx_checker.sv */
// checker: rebuilds lane words and checks status and training words
`timescale 1ns/1ps
`default_nettype none
module sosx_checker
  import sosx_pkg::*;
#(
  parameter int NCH = 64
) (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           ctl_bit,
  input  wire logic [NCH-1:0] dat_bit,
  input  wire logic           frame_req,
  input  wire logic           exp_start,
  input  wire logic           reg_we,
  input  wire logic [6:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // word capture, 12-bit mode only
  // ---------------------------------------------------------------
  logic [3:0]  ph;
  logic [1:0]  nb;
  logic        m12;
  logic [11:0] sc, sd, pc, pd, tp, tw, tq, cw, dw;
  logic [15:0] ov, ln, lo;
  logic [7:0]  hi, src;
  logic [3:0]  os;
  logic [12:0] bc, rc, rx;
  // 34 times a full byte of overhead needs fourteen bits
  logic [13:0] fc, fx;
  logic [23:0] ec, ic, iv, el;
  logic [47:0] ex;
  logic        eq, fq, wk;
  // a word ends where the next one loads; width changes end the check
  assign cw = {ctl_bit, sc[11:1]};
  assign dw = {dat_bit[0], sd[11:1]};
  assign wk = ph == 4'h0 && nb == 2'h2 && m12;
  assign rx = (13'h81 << os) - 13'h1;
  assign fx = (ov[7:0] == 8'h0) ? 14'h1 : 14'(FOT_MULT) * 14'(ov[7:0]);
  assign el = ({hi, lo} == 24'h0) ? 24'h0 : {hi, lo} - 24'h1;
  assign ex = 48'(el) * 48'(ln) + 48'(el) + 48'h1;
  // register mirrors, word history and run-length counters
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ph <= 4'h0;
      nb <= 2'h0;
      m12 <= 1'b1;
      tp <= R_TP1;
      ov <= R_OVH;
      ln <= R_LINE;
      lo <= R_EXP_LO;
      hi <= 8'h0;
      src <= 8'h0;
      os <= 4'hF;
    end else begin
      if (reg_we) begin
        case (reg_addr)
          A_EXP_SRC: src <= reg_wdata[7:0];
          A_EXP_LO:  lo <= reg_wdata;
          A_EXP_HI:  hi <= reg_wdata[7:0];
          A_OUT_SEL: os <= reg_wdata[3:0];
          A_OVH:     ov <= reg_wdata;
          A_LINE:    ln <= reg_wdata;
          A_TP1:     tp <= reg_wdata[11:0];
          A_BMODE:   m12 <= m12 && reg_wdata[1:0] == BM_12;
          default:   ;
        endcase
      end
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h0) begin
        nb <= (nb == 2'h2) ? nb : nb + 2'h1;
        pc <= cw;
        pd <= dw;
        tw <= tp;
        tq <= tw;
      end
      if (wk) begin
        bc <= cw[0] ? bc + 13'h1 : 13'h0;
        rc <= cw[1] ? rc + 13'h1 : 13'h0;
        fc <= cw[3] ? fc + 14'h1 : 14'h0;
        ec <= (cw[4] && !cw[3]) ? ec + 24'h1 : 24'h0;
      end
    end
    sc <= cw;
    sd <= dw;
    eq <= exp_start;
    fq <= frame_req;
    ic <= (exp_start && !eq) ? 24'h0 : ic + 24'h1;
    if (frame_req && !fq) iv <= ic;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_fixed_bits: assert property (wk |-> cw[11:6] == 6'h02)
    else $error("control word constant bits wrong");
  a_lanes_equal: assert property (dat_bit == {NCH{dat_bit[0]}})
    else $error("data lanes differ");
  a_row_in_frame: assert property (wk && cw[1] |-> cw[2])
    else $error("row valid outside frame valid");
  a_pix_in_row: assert property (wk && cw[0] |-> cw[1])
    else $error("pixel valid outside row valid");
  a_align_word: assert property (wk && !pc[1] && cw[1]
    |-> pd == {4'h0, ~tq[7:0]}) else $error("align word wrong");
  a_idle_fill: assert property (wk && !pc[0] && !(!pc[1] && cw[1])
    |-> pd == tq) else $error("idle training word wrong");
  a_burst_len: assert property (wk && pc[0] && !cw[0]
    |-> bc == BURST_LEN[12:0]) else $error("burst length wrong");
  a_single_slot: assert property (wk && pc[1] && !pc[0] && cw[1]
    |-> cw[0]) else $error("more than one slot between bursts");
  a_row_length: assert property (wk && pc[1] && !cw[1] && os != 4'hF
    |-> rc == rx) else $error("row length wrong");
  a_fot_length: assert property (wk && pc[3] && !cw[3] |-> fc == fx)
    else $error("overhead interval length wrong");
  a_fot_integ: assert property (wk && cw[3] |-> cw[4] && cw[5])
    else $error("overhead interval not integrating");
  a_int_expo: assert property (wk && pc[4] && !pc[3] && cw[3]
    && src == 8'h0 |-> 48'(ec) == ex) else $error("internal exposure wrong");
  a_ext_expo: assert property (wk && pc[4] && !pc[3] && cw[3]
    && src != 8'h0 |-> 32'(ec) * 12 <= 32'(iv) + 12
    && 32'(iv) <= 32'(ec) * 12 + 12) else $error("external exposure wrong");
endmodule
`default_nettype wire

/* File: dv/sosx_tb.sv */
// testbench: both link ends joined, driven over the software port
`timescale 1ns/1ps
`default_nettype none
module sosx_tb
  import sosx_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata, rd, tp;
  logic [11:0] pixel_word = 12'h0;
  logic [11:0] mon, last_pix;
  logic        pixel_take;
  logic [31:0] xs = 32'h55;
  int          npix = 0;
  int          failures = 0;
  int          check_count = 0;
  sosx_link #(.NCH(64)) lk();
  sosx_dev #(.NCH(64), .ROWS(4), .OH_WORDS(2)) i_sosx_dev (.clk(clk),
    .nrst(nrst), .lk(lk), .pixel_word(pixel_word),
    .pixel_take(pixel_take), .status_monitor_pins(mon));
  sosx_host i_sosx_host (.clk(clk), .nrst(nrst), .lk(lk), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  sosx_checker #(.NCH(64)) i_sosx_checker (.clk(clk), .nrst(nrst),
    .ctl_bit(lk.ctl_bit), .dat_bit(lk.dat_bit), .frame_req(lk.frame_req),
    .exp_start(lk.exp_start), .reg_we(lk.reg_we), .reg_addr(lk.reg_addr),
    .reg_wdata(lk.reg_wdata));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  // four rows make two passes of 128 << s pixels each
  function automatic logic [31:0] npx(input logic [1:0] s);
    return 32'h100 << s;
  endfunction
  function automatic logic [11:0] wmask(input logic [1:0] m);
    return (m == BM_10) ? 12'h3FF : (m == BM_8) ? 12'h0FF : 12'hFFF;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 rd = sw_rdata;
  endtask
  task automatic dwr(input logic [6:0] a, input logic [15:0] d);
    wr(H_DADDR, 32'(a));
    wr(H_DDATA, 32'(d));
  endtask
  // waits for frame valid, then for the idle status word, bounded
  task automatic wait_frame();
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 30000; n++) begin
      @(posedge clk);
      if (mon[B_FRM] === 1'b1) seen = 1'b1;
      if (seen && mon === IDLE_CTL) break;
    end
    chk(32'(seen && mon === IDLE_CTL), 32'h1);
  endtask
  task automatic run_frame(input logic [1:0] s, input logic ext);
    npix = 0;
    wr(H_CMD, 32'h8);
    if (ext) begin
      wr(H_CMD, 32'h2);
      repeat (40 + (rnd() & 32'hFF)) @(posedge clk);
      wr(H_CMD, 32'h3);
    end else
      wr(H_CMD, 32'h1);
    wr(H_CMD, 32'h0);
    wait_frame();
    repeat (60) @(posedge clk);
    chk(32'(npix), npx(s));
    rdr(H_PCNT);
    chk(rd & 32'hFFFFFF, npx(s));
    rdr(H_PIX);
    chk(rd & 32'hFFF, 32'(last_pix));
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  // pixel source: a fresh word every cycle, the taken one is kept
  always @(posedge clk) begin
    if (pixel_take === 1'b1) begin
      last_pix = pixel_word;
      npix = npix + 1;
    end
    pixel_word <= 12'(rnd());
  end
  // watchdog: well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wr(H_CMD, 32'h4);
    repeat (200) @(posedge clk);
    chk(32'(mon), 32'(IDLE_CTL));
    rdr(H_STAT);
    chk(32'(rd[24:0]), {7'h0, 1'b1, R_TP1, IDLE_CTL});
    rdr(4'hF);
    chk(rd, 32'h0);
    tp = rnd() & 32'hFFF;
    dwr(A_TP1, tp[15:0]);
    repeat (100) @(posedge clk);
    rdr(H_STAT);
    chk(32'(rd[23:12]), 32'(tp[11:0]));
    // bursts per row, overhead factor and exposure sweep together
    for (int i = 0; i < 3; i++) begin
      dwr(A_OUT_SEL, 16'(i));
      dwr(A_OVH, 16'h0C00 | 16'(i));
      dwr(A_EXP_LO, 16'(i));
      dwr(A_LINE, 16'(rnd() & 32'h7));
      run_frame(2'(i), 1'b0);
    end
    dwr(A_EXP_SRC, 16'(1 + (rnd() & 32'hFE)));
    run_frame(2'h2, 1'b1);
    dwr(A_EXP_SRC, 16'h0);
    // narrower words last: the checker stops at the first width change
    for (int m = 1; m < 3; m++) begin
      dwr(A_BMODE, 16'(m));
      wr(H_MODE, 32'(m));
      wr(H_CMD, 32'h4);
      repeat (300) @(posedge clk);
      rdr(H_STAT);
      chk(32'(rd[24:12]), {20'h1, tp[11:0] & wmask(2'(m))});
      chk(32'(rd[11:0]), 32'(IDLE_CTL));
    end
    complete_run();
  end
endmodule
`default_nettype wire
